// >>> dci_pkg.sv
// constants and types for the ddr3 command and address input decode
// assumes one clock; command pins already sampled on the ck crossing
package dci_pkg;

	// address field positions
	localparam int COL_W = 10; // column bits a0..a9
	localparam int AP_BIT = 10; // auto precharge / precharge all
	localparam int TDQS_BIT = 11; // mr1 termination strobe enable
	localparam int BC_BIT = 12; // burst chop, low means chop
	localparam int BA_W = 3; // bank address width
	localparam int ADDR_W_X8 = 16; // a0..a15
	localparam int ADDR_W_X16 = 15; // a0..a14
	localparam int OP_W = 16; // stored op-code width

	// termination enable fields inside mr1 and mr2
	localparam int RTT_NOM_B0 = 2;
	localparam int RTT_NOM_B1 = 6;
	localparam int RTT_NOM_B2 = 9;
	localparam int RTT_WR_B0 = 9;
	localparam int RTT_WR_B1 = 10;

	// mode register indices selected by bank address
	localparam logic [2:0] MR1_IDX = 3'h1;
	localparam logic [2:0] MR2_IDX = 3'h2;
	localparam logic [OP_W-1:0] MR_RESET = 16'h0000;

	// burst lengths in data beats
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;

	// ras_n, cas_n, we_n codes with chip select low
	localparam logic [2:0] CODE_MRS = 3'h0;
	localparam logic [2:0] CODE_REF = 3'h1;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_ACT = 3'h3;
	localparam logic [2:0] CODE_WR = 3'h4;
	localparam logic [2:0] CODE_RD = 3'h5;
	localparam logic [2:0] CODE_ZQ = 3'h6;
	localparam logic [2:0] CODE_NOP = 3'h7;

	// decoded command
	typedef enum logic [3:0] {
		DCI_NOP = 4'h0,
		DCI_ACT = 4'h1,
		DCI_RD = 4'h2,
		DCI_WR = 4'h3,
		DCI_PRE = 4'h4,
		DCI_REF = 4'h5,
		DCI_MRS = 4'h6,
		DCI_ZQ = 4'h7
	} dci_cmd_type;

	// write burst tracker states, one-hot
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_BURST = 2'h2
	} dci_wr_state_type;

endpackage : dci_pkg

// >>> dci_mask_lane.sv
// one byte lane of write data masking
// assumes beat_valid marks one data beat per dqs edge from the data path
`timescale 1ns/1ps

module dci_mask_lane (
	input wire logic mclk,
	input wire logic srst,
	input wire logic beat_valid, // one data beat this cycle
	input wire logic wr_active, // inside a write burst
	input wire logic dm, // mask level sampled with this beat
	input wire logic dm_en, // pin acts as data mask
	output logic keep // registered: write this beat
);

	logic next_keep; // next keep value

	////////////////////////////////////////////////////////////////////////
	// drop the beat when the mask is high with it
	always_comb begin
		next_keep = beat_valid && wr_active && !(dm && dm_en);
	end

	// register the decision
	always_ff @(posedge mclk) begin
		if (srst) begin
			keep <= 1'b0;
		end else begin
			keep <= next_keep;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_mask_drops_beat: assert property (@(posedge mclk) disable iff (srst)
		(beat_valid && wr_active && dm && dm_en) |=> !keep)
		else $error("masked beat was kept");

	chk_unmasked_kept: assert property (@(posedge mclk) disable iff (srst)
		(beat_valid && wr_active && !dm) |=> keep)
		else $error("unmasked beat was dropped");

endmodule : dci_mask_lane

// >>> dci_cmd_decode.sv
// ddr3 command and address input decode, device side
// assumes pins are presented synchronous to mclk, one sample per ck crossing
// What this block does
// - capture address and control only at crossing
// - chip select high masks the command
// - decode command from ras cas we cs
// - discard write beats with mask high
// - one mask sample per data beat
// - x8 mr1 bit picks mask or tdqs
// - bank inputs pick bank of command
// - bank inputs pick mode register on mrs
// - a10 requests auto precharge on access
// - a10 high precharges all banks
// - single bank precharge uses bank inputs
// - row on activate, column on access
// - mrs loads address as op-code
// - a12 low chops the burst
// - registered odt enables termination
// - x8 termination covers dq strobes mask tdqs
// - odt ignored when rtt fields disabled
`timescale 1ns/1ps

module dci_cmd_decode #(
	parameter bit ORG_X16 = 1'b0, // 0 for x8, 1 for x16
	parameter int ADDR_W = ORG_X16 ? dci_pkg::ADDR_W_X16 : dci_pkg::ADDR_W_X8,
	parameter int LANES = ORG_X16 ? 2 : 1 // data mask lanes
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic cs_n, // chip select
	input wire logic ras_n, // row strobe
	input wire logic cas_n, // column strobe
	input wire logic we_n, // write enable
	input wire logic [dci_pkg::BA_W-1:0] ba, // bank address
	input wire logic [ADDR_W-1:0] addr, // address inputs
	input wire logic odt, // termination request
	input wire logic beat_valid, // one write data beat
	input wire logic [LANES-1:0] dm, // mask per byte lane
	output logic cmd_valid, // one-cycle decoded command
	output dci_pkg::dci_cmd_type cmd, // decoded command
	output logic [dci_pkg::BA_W-1:0] cmd_bank, // target bank
	output logic [ADDR_W-1:0] cmd_row, // row on activate
	output logic [dci_pkg::COL_W-1:0] cmd_col, // column on access
	output logic auto_pre, // auto precharge after burst
	output logic burst_chop, // chopped burst of four
	output logic pre_all, // precharge all banks
	output logic [dci_pkg::OP_W-1:0] mr1, // mode register 1
	output logic [dci_pkg::OP_W-1:0] mr2, // mode register 2
	output logic mr_load, // one-cycle mode register write
	output logic [dci_pkg::BA_W-1:0] mr_sel, // written register
	output logic [dci_pkg::OP_W-1:0] mr_op, // written op-code
	output logic tdqs_en, // x8 pin is termination strobe
	output logic term_on, // termination on dq strobes mask
	output logic term_tdqs, // termination on tdqs pair
	output logic wr_active, // write burst in progress
	output logic [LANES-1:0] beat_keep // registered keep per lane
);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	if (ADDR_W != (ORG_X16 ? dci_pkg::ADDR_W_X16 : dci_pkg::ADDR_W_X8)) begin : g_bad_aw
		$error("address width does not match organization");
	end
	if (LANES != (ORG_X16 ? 2 : 1)) begin : g_bad_lanes
		$error("lane count does not match organization");
	end

	////////////////////////////////////////////////////////////////////////
	// command decode
	logic [2:0] pin_code; // ras cas we as sampled
	logic selected; // chip select asserted
	logic next_cmd_valid;
	dci_pkg::dci_cmd_type next_cmd;
	logic [dci_pkg::BA_W-1:0] next_cmd_bank;
	logic [ADDR_W-1:0] next_cmd_row;
	logic [dci_pkg::COL_W-1:0] next_cmd_col;
	logic next_auto_pre;
	logic next_burst_chop;
	logic next_pre_all;

	// decode pins sampled this cycle
	always_comb begin
		pin_code = {ras_n, cas_n, we_n};
		selected = !cs_n;
		next_cmd = dci_pkg::DCI_NOP;
		case (pin_code)
			dci_pkg::CODE_MRS: next_cmd = dci_pkg::DCI_MRS;
			dci_pkg::CODE_REF: next_cmd = dci_pkg::DCI_REF;
			dci_pkg::CODE_PRE: next_cmd = dci_pkg::DCI_PRE;
			dci_pkg::CODE_ACT: next_cmd = dci_pkg::DCI_ACT;
			dci_pkg::CODE_WR: next_cmd = dci_pkg::DCI_WR;
			dci_pkg::CODE_RD: next_cmd = dci_pkg::DCI_RD;
			dci_pkg::CODE_ZQ: next_cmd = dci_pkg::DCI_ZQ;
			default: next_cmd = dci_pkg::DCI_NOP;
		endcase
		if (!selected) begin
			next_cmd = dci_pkg::DCI_NOP;
		end
		// nop is not reported as a command
		next_cmd_valid = selected && (pin_code != dci_pkg::CODE_NOP);
		// hold fields unless a command uses them
		next_cmd_bank = cmd_bank;
		next_cmd_row = cmd_row;
		next_cmd_col = cmd_col;
		next_auto_pre = auto_pre;
		next_burst_chop = burst_chop;
		next_pre_all = pre_all;
		case (next_cmd)
			dci_pkg::DCI_ACT: begin
				next_cmd_bank = ba;
				next_cmd_row = addr;
			end
			dci_pkg::DCI_RD, dci_pkg::DCI_WR: begin
				next_cmd_bank = ba;
				next_cmd_col = addr[dci_pkg::COL_W-1:0];
				next_auto_pre = addr[dci_pkg::AP_BIT];
				next_burst_chop = !addr[dci_pkg::BC_BIT];
			end
			dci_pkg::DCI_PRE: begin
				next_cmd_bank = ba;
				next_pre_all = addr[dci_pkg::AP_BIT];
			end
			default: begin
				next_cmd_bank = cmd_bank;
			end
		endcase
	end

	// register the decoded command
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_valid <= 1'b0;
			cmd <= dci_pkg::DCI_NOP;
			cmd_bank <= '0;
			cmd_row <= '0;
			cmd_col <= '0;
			auto_pre <= 1'b0;
			burst_chop <= 1'b0;
			pre_all <= 1'b0;
		end else begin
			cmd_valid <= next_cmd_valid;
			cmd <= next_cmd;
			cmd_bank <= next_cmd_bank;
			cmd_row <= next_cmd_row;
			cmd_col <= next_cmd_col;
			auto_pre <= next_auto_pre;
			burst_chop <= next_burst_chop;
			pre_all <= next_pre_all;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode registers
	logic is_mrs; // mode register set this cycle
	logic [dci_pkg::OP_W-1:0] op_in; // address widened to op-code
	logic [dci_pkg::OP_W-1:0] next_mr1;
	logic [dci_pkg::OP_W-1:0] next_mr2;
	logic next_mr_load;
	logic [dci_pkg::BA_W-1:0] next_mr_sel;
	logic [dci_pkg::OP_W-1:0] next_mr_op;

	// route the op-code to the register chosen by bank
	always_comb begin
		is_mrs = selected && (pin_code == dci_pkg::CODE_MRS);
		op_in = dci_pkg::OP_W'(addr);
		next_mr1 = mr1;
		next_mr2 = mr2;
		next_mr_load = is_mrs;
		next_mr_sel = mr_sel;
		next_mr_op = mr_op;
		if (is_mrs) begin
			next_mr_sel = ba;
			next_mr_op = op_in;
			if (ba == dci_pkg::MR1_IDX) begin
				next_mr1 = op_in;
			end else if (ba == dci_pkg::MR2_IDX) begin
				next_mr2 = op_in;
			end
		end
	end

	// register mode state
	always_ff @(posedge mclk) begin
		if (srst) begin
			mr1 <= dci_pkg::MR_RESET;
			mr2 <= dci_pkg::MR_RESET;
			mr_load <= 1'b0;
			mr_sel <= '0;
			mr_op <= '0;
		end else begin
			mr1 <= next_mr1;
			mr2 <= next_mr2;
			mr_load <= next_mr_load;
			mr_sel <= next_mr_sel;
			mr_op <= next_mr_op;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin function and termination
	logic rtt_off; // both rtt fields disabled
	logic dm_en; // shared pin acts as mask
	logic next_tdqs_en;
	logic next_term_on;
	logic next_term_tdqs;

	// x16 ignores the tdqs bit; controller keeps it clear there
	always_comb begin
		next_tdqs_en = !ORG_X16 && mr1[dci_pkg::TDQS_BIT];
		dm_en = !tdqs_en;
		rtt_off = !(mr1[dci_pkg::RTT_NOM_B0] || mr1[dci_pkg::RTT_NOM_B1]
			|| mr1[dci_pkg::RTT_NOM_B2] || mr2[dci_pkg::RTT_WR_B0]
			|| mr2[dci_pkg::RTT_WR_B1]);
		next_term_on = odt && !rtt_off;
		next_term_tdqs = next_term_on && next_tdqs_en;
	end

	// register pin function and termination enables
	always_ff @(posedge mclk) begin
		if (srst) begin
			tdqs_en <= 1'b0;
			term_on <= 1'b0;
			term_tdqs <= 1'b0;
		end else begin
			tdqs_en <= next_tdqs_en;
			term_on <= next_term_on;
			term_tdqs <= next_term_tdqs;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write burst tracker
	dci_pkg::dci_wr_state_type wr_state, next_wr_state;
	logic [3:0] beats_left, next_beats_left; // beats still due
	logic next_wr_active;

	// open a burst on write, close after its last beat
	always_comb begin
		next_wr_state = wr_state;
		next_beats_left = beats_left;
		case (wr_state)
			dci_pkg::WR_IDLE: begin
				if (selected && pin_code == dci_pkg::CODE_WR) begin
					next_wr_state = dci_pkg::WR_BURST;
					next_beats_left = addr[dci_pkg::BC_BIT] ? dci_pkg::BEATS_FULL
						: dci_pkg::BEATS_CHOP;
				end
			end
			dci_pkg::WR_BURST: begin
				if (beat_valid) begin
					next_beats_left = beats_left - 4'h1;
					if (beats_left == 4'h1) begin
						next_wr_state = dci_pkg::WR_IDLE;
					end
				end
			end
			default: begin
				next_wr_state = dci_pkg::WR_IDLE;
				next_beats_left = 4'h0;
			end
		endcase
		next_wr_active = (next_wr_state == dci_pkg::WR_BURST);
	end

	// register burst state
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_state <= dci_pkg::WR_IDLE;
			beats_left <= 4'h0;
			wr_active <= 1'b0;
		end else begin
			wr_state <= next_wr_state;
			beats_left <= next_beats_left;
			wr_active <= next_wr_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte lane masks, one per lane
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		dci_mask_lane u_lane (
			.mclk(mclk),
			.srst(srst),
			.beat_valid(beat_valid),
			.wr_active(wr_active),
			.dm(dm[i]),
			.dm_en(dm_en),
			.keep(beat_keep[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	chk_deselect_masks: assert property (cs_n |=> !cmd_valid)
		else $error("command taken with chip select high");

	chk_activate_decode: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h3) |=> cmd_valid && cmd == dci_pkg::DCI_ACT)
		else $error("activate not decoded");

	chk_write_decode: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h4) |=> cmd_valid && cmd == dci_pkg::DCI_WR)
		else $error("write not decoded");

	chk_bank_capture: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h5) |=> cmd_bank == $past(ba))
		else $error("bank not captured on read");

	chk_auto_pre_flag: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h5) |=> auto_pre == $past(addr[10]))
		else $error("auto precharge flag wrong");

	chk_precharge_all: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h2) |=> pre_all == $past(addr[10]))
		else $error("precharge scope wrong");

	chk_chop_flag: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h4) |=> burst_chop == !$past(addr[12]))
		else $error("burst chop flag wrong");

	chk_mr1_load: assert property (
		(!cs_n && {ras_n, cas_n, we_n} == 3'h0 && ba == 3'h1)
		|=> mr_load && mr1 == 16'(($past(addr))))
		else $error("mode register 1 not loaded");

	chk_odt_gated: assert property (
		(odt && mr1 == 16'h0000 && mr2 == 16'h0000) |=> !term_on)
		else $error("odt honoured with rtt disabled");

	chk_tdqs_follow_mr1: assert property (tdqs_en == (!ORG_X16 && $past(mr1[11])))
		else $error("tdqs enable does not follow mode register 1");

	chk_burst_length: assert property (
		(!wr_active ##1 wr_active) |-> beats_left inside {4'h4, 4'h8})
		else $error("burst length not four or eight");

	cov_write_burst: cover property (wr_active ##1 !wr_active);
	cov_mrs_mr1: cover property (mr_load && mr_sel == 3'h1);
	cov_pre_all: cover property (cmd_valid && cmd == dci_pkg::DCI_PRE && pre_all);
	cov_term_on: cover property (term_on && term_tdqs);

endmodule : dci_cmd_decode

// >>> dci_ctrl_model.sv
// controller-side model driving the command, address, termination and mask pins
// assumes the bench hands it one request per mclk cycle; pins follow one edge later
`timescale 1ns/1ps

module dci_ctrl_model (
	input wire logic mclk,
	input wire logic go, // issue this slot
	input wire logic [2:0] code, // ras cas we levels
	input wire logic [2:0] rba,
	input wire logic [15:0] raddr,
	input wire logic rodt,
	input wire logic rbeat,
	input wire logic rdm,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [15:0] addr,
	output logic odt,
	output logic beat_valid,
	output logic dm
);
	////////////////////////////////////////////////////////////////
	// defined levels at time zero, chip deselected
	initial begin
		{cs_n, ras_n, cas_n, we_n, ba, addr, odt, beat_valid, dm} = {4'hf, 3'h0, 16'h0, 3'h0};
	end

	// pins change just after the edge and hold a whole cycle
	always @(posedge mclk) begin
		cs_n <= ~go;
		{ras_n, cas_n, we_n} <= code;
		ba <= rba;
		addr <= raddr;
		odt <= rodt;
		beat_valid <= rbeat;
		dm <= rdm;
	end
endmodule : dci_ctrl_model

// >>> dci_cmd_decode_bench.sv
// self-checking bench for the command and address input decode, x8 organisation
// assumes the controller model above drives every decode input except mclk and srst
`timescale 1ns/1ps

`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h seen %h", nm, e, s); end end

module dci_cmd_decode_bench;
	typedef struct {logic [3:0] c; logic [2:0] b; logic [15:0] f;} dci_note_type;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic go = 1'b0, rodt = 1'b0, rbeat = 1'b0, rdm = 1'b0;
	logic [2:0] code = 3'h7, rba = 3'h0;
	logic [15:0] raddr = 16'h0;
	logic cs_n, ras_n, cas_n, we_n, odt, beat_valid, cmd_valid, auto_pre, burst_chop, pre_all;
	logic tdqs_en, term_on, term_tdqs, tq = 1'b0, bpend = 1'b0, tx = 1'b0, tt = 1'b0;
	logic mr_load, wr_active; // pulse per mode register set, write burst open
	logic [0:0] dm, beat_keep;
	logic [1:0] kb; // oldest beat note: wr_active, keep
	logic [2:0] ba, cmd_bank, mr_sel, sb;
	logic [15:0] addr, cmd_row, mr1, mr2, mr_op, sf, sh1 = 16'h0, sh2 = 16'h0;
	logic [9:0] cmd_col;
	dci_pkg::dci_cmd_type cmd;
	dci_note_type cq[$];
	logic [1:0] kq[$];
	int mismatches = 0;
	int samples_checked = 0;

	always #2.5 mclk = ~mclk;

	dci_ctrl_model dci_ctrl_model_inst (.mclk(mclk), .go(go), .code(code), .rba(rba),
		.raddr(raddr), .rodt(rodt), .rbeat(rbeat), .rdm(rdm), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .beat_valid(beat_valid),
		.dm(dm[0]));

	dci_cmd_decode #(.ORG_X16(1'b0)) dci_cmd_decode_inst (.mclk(mclk), .srst(srst),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
		.odt(odt), .beat_valid(beat_valid), .dm(dm), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_bank(cmd_bank), .cmd_row(cmd_row), .cmd_col(cmd_col), .auto_pre(auto_pre),
		.burst_chop(burst_chop), .pre_all(pre_all), .mr1(mr1), .mr2(mr2), .mr_load(mr_load),
		.mr_sel(mr_sel), .mr_op(mr_op), .tdqs_en(tdqs_en), .term_on(term_on),
		.term_tdqs(term_tdqs), .wr_active(wr_active), .beat_keep(beat_keep));

	////////////////////////////////////////////////////////////////
	// pin code to decoded command
	function automatic logic [3:0] to_cmd(input logic [2:0] c);
		case (c)
			dci_pkg::CODE_MRS: return dci_pkg::DCI_MRS;
			dci_pkg::CODE_REF: return dci_pkg::DCI_REF;
			dci_pkg::CODE_PRE: return dci_pkg::DCI_PRE;
			dci_pkg::CODE_ACT: return dci_pkg::DCI_ACT;
			dci_pkg::CODE_WR: return dci_pkg::DCI_WR;
			dci_pkg::CODE_RD: return dci_pkg::DCI_RD;
			dci_pkg::CODE_ZQ: return dci_pkg::DCI_ZQ;
			default: return dci_pkg::DCI_NOP;
		endcase
	endfunction : to_cmd

	// any rtt field set in mr1 or mr2
	function automatic logic rtt(input logic [15:0] m1, input logic [15:0] m2);
		return m1[dci_pkg::RTT_NOM_B0] | m1[dci_pkg::RTT_NOM_B1] | m1[dci_pkg::RTT_NOM_B2]
			| m2[dci_pkg::RTT_WR_B0] | m2[dci_pkg::RTT_WR_B1];
	endfunction : rtt

	// one request slot; notes the expected decode
	task automatic slot(input logic g, input logic [2:0] c, input logic [2:0] b,
		input logic [15:0] a, input logic bt);
		dci_note_type n;
		go <= g;
		code <= c;
		rba <= b;
		raddr <= a;
		rodt <= 1'($urandom);
		rbeat <= bt;
		rdm <= 1'($urandom);
		n.c = to_cmd(c);
		n.b = (c == dci_pkg::CODE_REF || c == dci_pkg::CODE_ZQ) ? 3'h0 : b;
		n.f = 16'h0;
		if (c == dci_pkg::CODE_ACT || c == dci_pkg::CODE_MRS) n.f = a;
		if (c == dci_pkg::CODE_RD || c == dci_pkg::CODE_WR) n.f = {4'h0, a[10], ~a[12], a[9:0]};
		if (c == dci_pkg::CODE_PRE) begin
			n.f = {15'h0, a[10]};
			if (a[10]) n.b = 3'h0;
		end
		if (g && c == dci_pkg::CODE_MRS && b == dci_pkg::MR1_IDX) tq = a[dci_pkg::TDQS_BIT];
		if (g && c != dci_pkg::CODE_NOP) cq.push_back(n);
		@(posedge mclk);
	endtask : slot

	// write burst, then one stray beat past its end
	task automatic wburst(input logic full);
		int j;
		logic [15:0] a;
		a = 16'($urandom);
		a[dci_pkg::BC_BIT] = full;
		slot(1'b1, dci_pkg::CODE_WR, 3'($urandom), a, 1'b0);
		for (j = 0; j <= (full ? 8 : 4); j++) begin
			slot(1'b0, 3'($urandom), 3'h0, 16'h0, 1'b1);
			// burst still open at the check unless this is its last beat or the stray one
			kq.push_back({j < (full ? 7 : 3), (j < (full ? 8 : 4)) ? (tq | ~rdm) : 1'b0});
		end
		repeat (3) slot(1'b0, 3'h7, 3'h0, 16'h0, 1'b0);
		@(negedge mclk);
		`CHK("tdqs_en", tq, tdqs_en)
		@(posedge mclk);
	endtask : wburst

	////////////////////////////////////////////////////////////////
	// result watcher: settled outputs at the falling edge
	always @(negedge mclk) begin
		if (!srst) begin
			if (cmd_valid && cq.size() == 0) `CHK("cmd_valid", 1'b0, cmd_valid)
			else if (cmd_valid) begin
				case (cmd)
					dci_pkg::DCI_ACT: {sb, sf} = {cmd_bank, cmd_row};
					dci_pkg::DCI_RD, dci_pkg::DCI_WR:
						{sb, sf} = {cmd_bank, 4'h0, auto_pre, burst_chop, cmd_col};
					dci_pkg::DCI_PRE: {sb, sf} = {pre_all ? 3'h0 : cmd_bank, 15'h0, pre_all};
					dci_pkg::DCI_MRS: {sb, sf} = {mr_sel, mr_sel == 3'h1 ? mr1 :
						mr_sel == 3'h2 ? mr2 : mr_op};
					default: {sb, sf} = 19'h0;
				endcase
				`CHK("cmd", cq[0].c, cmd)
				`CHK("bank", cq[0].b, sb)
				`CHK("fields", cq[0].f, sf)
				`CHK("mr_load", cq[0].c == dci_pkg::DCI_MRS, mr_load)
				void'(cq.pop_front());
			end
			if (bpend) begin
				kb = kq.pop_front();
				`CHK("beat_keep", kb[0], beat_keep)
				`CHK("wr_active", kb[1], wr_active)
			end
			`CHK("term_on", tx, term_on)
			`CHK("term_tdqs", tx & tt, term_tdqs)
		end
		bpend = !srst && beat_valid;
		tx = !srst && odt && rtt(sh1, sh2);
		tt = sh1[dci_pkg::TDQS_BIT];
		// reset clears both mode registers
		if (srst) {sh1, sh2} = 32'h0;
		if (!srst && !cs_n && {ras_n, cas_n, we_n} == dci_pkg::CODE_MRS) begin
			if (ba == dci_pkg::MR1_IDX) sh1 = addr;
			if (ba == dci_pkg::MR2_IDX) sh2 = addr;
		end
	end

	// verdict and end of run
	task automatic tally_and_finish;
		if (cq.size() != 0 || kq.size() != 0) mismatches++;
		$display("checked %0d mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// watchdog well past the expected run length
	initial begin
		#20000;
		mismatches++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int i;
		logic [15:0] a;
		void'($urandom(32'hbe20));
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		// every code selected, then deselected with live codes
		for (i = 0; i < 32; i++) slot(i < 16, 3'(i), 3'($urandom), 16'($urandom), 1'b0);
		// access and precharge qualifier corners
		for (i = 0; i < 12; i++) begin
			a = 16'($urandom);
			a[dci_pkg::AP_BIT] = i[0];
			a[dci_pkg::BC_BIT] = i[1];
			slot(1'b1, i < 4 ? dci_pkg::CODE_RD : i < 8 ? dci_pkg::CODE_WR : dci_pkg::CODE_PRE,
				3'($urandom), a, 1'b0);
		end
		// every mode register index, back to back
		for (i = 0; i < 8; i++) slot(1'b1, dci_pkg::CODE_MRS, 3'(i), 16'($urandom), 1'b0);
		// drain, then reset mid-run: the bare writes above left a burst open
		repeat (3) slot(1'b0, 3'h7, 3'h0, 16'h0, 1'b0);
		srst <= 1'b1;
		repeat (4) slot(1'b0, 3'($urandom), 3'h0, 16'h0, 1'b0);
		srst <= 1'b0;
		// termination off, then write rtt only, then nominal rtt with tdqs
		slot(1'b1, dci_pkg::CODE_MRS, dci_pkg::MR1_IDX, 16'h0, 1'b0);
		slot(1'b1, dci_pkg::CODE_MRS, dci_pkg::MR2_IDX, 16'h0, 1'b0);
		repeat (8) slot(1'b0, 3'($urandom), 3'h0, 16'h0, 1'b0);
		slot(1'b1, dci_pkg::CODE_MRS, dci_pkg::MR2_IDX, 16'h0200, 1'b0);
		repeat (8) slot(1'b0, 3'($urandom), 3'h0, 16'h0, 1'b0);
		slot(1'b1, dci_pkg::CODE_MRS, dci_pkg::MR1_IDX, 16'h0804, 1'b0);
		// write bursts: mask pin as tdqs, then as data mask
		wburst(1'b0);
		slot(1'b1, dci_pkg::CODE_MRS, dci_pkg::MR1_IDX, 16'h0004, 1'b0);
		wburst(1'b0);
		wburst(1'b1);
		tally_and_finish();
	end
endmodule : dci_cmd_decode_bench
